/* verilog/clk_ctl_pkg.sv */
// Constants and carrier types for the clock gating and chip reset control block.
// Assumes model-specific register accesses arrive as one-cycle requests on the core clock.
package clk_ctl_pkg;

  localparam int unsigned NUM_CLK  = 47;
  localparam int unsigned NUM_REQ  = 46;
  localparam int unsigned PLL_BIT  = 46;
  localparam int unsigned DLY_W    = 24;
  localparam int unsigned SPARE_HI = 23;
  localparam int unsigned REV_W    = 8;

  localparam logic [31:0] ADDR_CLOCK_KILL_MASK       = 32'h5170_0010;
  localparam logic [31:0] ADDR_CLOCK_REQUEST_STATUS  = 32'h5170_0011;
  localparam logic [31:0] ADDR_DEBUG_CLOCK_STOP_MASK = 32'h5170_0012;
  localparam logic [31:0] ADDR_SLEEP_MONITOR_MASK    = 32'h5170_0013;
  localparam logic [31:0] ADDR_SYSTEM_RESET_CONTROL  = 32'h5170_0014;
  localparam logic [31:0] ADDR_DEBUG_CLOCK_CONTROL   = 32'h5170_0016;
  localparam logic [31:0] ADDR_SILICON_REVISION_ID   = 32'h5170_0017;

  localparam logic [63:0] RST_CLOCK_KILL_MASK       = 64'h0;
  localparam logic [63:0] RST_DEBUG_CLOCK_STOP_MASK = 64'h0;
  localparam logic [63:0] RST_SLEEP_MONITOR_MASK    = 64'h0;
  localparam logic [63:0] RST_DEBUG_CLOCK_CONTROL   = 64'h2;

  // Bit position of the whole-device reset trigger
  localparam int unsigned CHIP_RESET_BIT = 0;

  // Delay count unit in PCI clock cycles
  localparam int unsigned DLY_UNIT_PCI = 16;
  localparam logic [3:0]  DLY_PRE_LAST = 4'(DLY_UNIT_PCI - 1);

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
  } msr_req_t;

  typedef enum logic [3:0] {
    SLP_IDLE  = 4'b0001,
    SLP_WAIT  = 4'b0010,
    SLP_ACK   = 4'b0100,
    SLP_GATED = 4'b1000
  } sleep_state_t;

endpackage

/* verilog/clock_gate_and_chip_reset_ctl.sv */
// Clock kill, clock request status, sleep acknowledge and chip reset control.
// Assumes functional blocks drive their clock requests synchronous to i_core_clk and that
// i_pci_tick is a one-cycle pulse per PCI clock cycle.
//
// Summary of operation
// [RQ1] Each set kill mask bit stops its clock at once, unconditionally.
// [RQ2] Software uses the kill mask only for debug, never in normal operation.
// [RQ3] Status bit 46 reads the inverse of kill mask bit 46 (PHY PLL).
// [RQ4] Status bits 45..0 read 1 while the block requests its clock.
// [RQ5] Status shows the request only, even when the clock is killed.
// [RQ6] Status bits 63..47 always read zero.
// [RQ7] Without delay gating, suspend acknowledge stays high while any monitored clock is still requested, until a nonzero delay times out.
// [RQ8] When all monitored clocks go idle, suspend acknowledge is asserted low.
// [RQ9] Software keeps delay gating select clear when relying on the monitor mask.
// [RQ10] Writing 1 to reset bit 0 resets the whole device and this register.
// [RQ11] Chip reset excludes the boundary-scan test logic; everything else resets.
// [RQ12] A write setting the chip reset bit never gets a write response.
// [RQ13] Reset register bits 23..1 are plain storage; software writes zero.
// [RQ14] Reset register bits 63..24 always read zero.
// [RQ15] Revision register gives an 8-bit read-only code in the low byte.
// [RQ16] Software never writes the two debug test registers.
// [RQ17] With delay gating selected, gate after the delay, ignoring the monitor mask.
// [RQ18] Without delay gating, a nonzero delay times out the wait for idle clocks.
// [RQ19] Delay counts are in units of sixteen PCI clock cycles.
module clock_gate_and_chip_reset_ctl #(
  parameter logic [7:0] REVISION = 8'h00  // Arbitrary value
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire clk_ctl_pkg::msr_req_t i_msr,
  output logic                       o_msr_rsp,
  output logic [63:0]                o_msr_rdata,
  input  wire logic [45:0]           i_clk_req,
  input  wire logic [45:0]           i_pm_clk_disable,
  input  wire logic                  i_delay_gating_select,
  input  wire logic [23:0]           i_gating_delay,
  input  wire logic                  i_pci_tick,
  input  wire logic                  i_sleep_req,
  output logic                       o_suspend_ack_n,
  output logic [46:0]                o_clk_run,
  output logic                       o_chip_reset
);

  logic [46:0]               kill;
  logic [63:0]               stop_mask;
  logic [45:0]               sleep_monitor_bits;
  logic [63:0]               dbg_ctl;
  logic [22:0]               rst_spare;
  logic [46:0]               next_kill;
  logic [63:0]               next_stop_mask;
  logic [45:0]               next_sleep_monitor_bits;
  logic [63:0]               next_dbg_ctl;
  logic [22:0]               next_rst_spare;
  logic                      next_msr_rsp;
  logic [63:0]               next_msr_rdata;
  logic                      next_chip_reset;
  logic                      rd;
  logic                      wr;
  logic                      chip_rst_wr;
  logic [63:0]               status;

  clk_ctl_pkg::sleep_state_t state;
  clk_ctl_pkg::sleep_state_t next_state;
  logic [3:0]                pre;
  logic [3:0]                next_pre;
  logic [23:0]               dly_cnt;
  logic [23:0]               next_dly_cnt;
  logic                      unit_tick;
  logic                      monitored_busy;

  assign rd          = i_msr.valid && !i_msr.write;
  assign wr          = i_msr.valid && i_msr.write;
  assign chip_rst_wr = wr && (i_msr.addr == clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL)
                       && i_msr.wdata[clk_ctl_pkg::CHIP_RESET_BIT];
  // Request bits pass straight through, the PLL bit is the inverted kill bit
  assign status = {17'h0, ~kill[clk_ctl_pkg::PLL_BIT], i_clk_req}; // [RQ3] [RQ4] [RQ5] [RQ6]

  // Register file
  always_comb begin
    next_kill               = kill;
    next_stop_mask          = stop_mask;
    next_sleep_monitor_bits = sleep_monitor_bits;
    next_dbg_ctl            = dbg_ctl;
    next_rst_spare          = rst_spare;
    next_msr_rsp            = i_msr.valid && !chip_rst_wr; // [RQ12]
    next_msr_rdata          = 64'h0;
    next_chip_reset         = chip_rst_wr; // [RQ10]
    if (wr) begin
      unique case (i_msr.addr)
        clk_ctl_pkg::ADDR_CLOCK_KILL_MASK:       next_kill = i_msr.wdata[46:0];
        clk_ctl_pkg::ADDR_DEBUG_CLOCK_STOP_MASK: next_stop_mask = i_msr.wdata;
        clk_ctl_pkg::ADDR_SLEEP_MONITOR_MASK:    next_sleep_monitor_bits = i_msr.wdata[45:0];
        clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL:  next_rst_spare = i_msr.wdata[23:1]; // [RQ13]
        clk_ctl_pkg::ADDR_DEBUG_CLOCK_CONTROL:   next_dbg_ctl = i_msr.wdata;
        default: ;
      endcase
    end
    if (rd) begin
      unique case (i_msr.addr)
        clk_ctl_pkg::ADDR_CLOCK_KILL_MASK:       next_msr_rdata = {17'h0, kill};
        clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS:  next_msr_rdata = status;
        clk_ctl_pkg::ADDR_DEBUG_CLOCK_STOP_MASK: next_msr_rdata = stop_mask;
        clk_ctl_pkg::ADDR_SLEEP_MONITOR_MASK:    next_msr_rdata = {18'h0, sleep_monitor_bits};
        clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL:  next_msr_rdata = {40'h0, rst_spare, 1'b0}; // [RQ14]
        clk_ctl_pkg::ADDR_DEBUG_CLOCK_CONTROL:   next_msr_rdata = dbg_ctl;
        clk_ctl_pkg::ADDR_SILICON_REVISION_ID:   next_msr_rdata = {56'h0, REVISION}; // [RQ15]
        default:                                 next_msr_rdata = 64'h0;
      endcase
    end
    // Chip reset returns every register here to its reset value
    if (o_chip_reset) begin
      next_kill               = clk_ctl_pkg::RST_CLOCK_KILL_MASK[46:0]; // [RQ10] [RQ11]
      next_stop_mask          = clk_ctl_pkg::RST_DEBUG_CLOCK_STOP_MASK;
      next_sleep_monitor_bits = clk_ctl_pkg::RST_SLEEP_MONITOR_MASK[45:0];
      next_dbg_ctl            = clk_ctl_pkg::RST_DEBUG_CLOCK_CONTROL;
      next_rst_spare          = 23'h0;
      next_msr_rsp            = 1'b0;
      next_msr_rdata          = 64'h0;
      next_chip_reset         = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      kill               <= clk_ctl_pkg::RST_CLOCK_KILL_MASK[46:0];
      stop_mask          <= clk_ctl_pkg::RST_DEBUG_CLOCK_STOP_MASK;
      sleep_monitor_bits <= clk_ctl_pkg::RST_SLEEP_MONITOR_MASK[45:0];
      dbg_ctl            <= clk_ctl_pkg::RST_DEBUG_CLOCK_CONTROL;
      rst_spare          <= 23'h0;
      o_msr_rsp          <= 1'b0;
      o_msr_rdata        <= 64'h0;
      o_chip_reset       <= 1'b0;
    end else begin
      kill               <= next_kill;
      stop_mask          <= next_stop_mask;
      sleep_monitor_bits <= next_sleep_monitor_bits;
      dbg_ctl            <= next_dbg_ctl;
      rst_spare          <= next_rst_spare;
      o_msr_rsp          <= next_msr_rsp;
      o_msr_rdata        <= next_msr_rdata;
      o_chip_reset       <= next_chip_reset;
    end
  end

  // Sleep sequencing
  assign monitored_busy = |(i_clk_req & sleep_monitor_bits);
  assign unit_tick      = i_pci_tick && (pre == clk_ctl_pkg::DLY_PRE_LAST); // [RQ19]

  always_comb begin
    next_state   = state;
    next_pre     = pre;
    next_dly_cnt = dly_cnt;
    if (i_pci_tick) begin
      next_pre = pre + 4'h1;
    end
    if (unit_tick && dly_cnt != 24'h0) begin
      next_dly_cnt = dly_cnt - 24'h1;
    end
    unique case (state)
      clk_ctl_pkg::SLP_IDLE: begin
        next_pre     = 4'h0;
        next_dly_cnt = i_gating_delay;
        if (i_sleep_req) begin
          next_state = i_delay_gating_select ? clk_ctl_pkg::SLP_ACK : clk_ctl_pkg::SLP_WAIT; // [RQ17]
        end
      end
      clk_ctl_pkg::SLP_WAIT: begin
        if (!i_sleep_req) begin
          next_state = clk_ctl_pkg::SLP_IDLE;
        end else if (!monitored_busy) begin
          next_state = clk_ctl_pkg::SLP_GATED; // [RQ8]
        end else if (i_gating_delay != 24'h0 && dly_cnt == 24'h0) begin
          next_state = clk_ctl_pkg::SLP_GATED; // [RQ18]
        end
      end
      clk_ctl_pkg::SLP_ACK: begin
        if (!i_sleep_req) begin
          next_state = clk_ctl_pkg::SLP_IDLE;
        end else if (dly_cnt == 24'h0) begin
          next_state = clk_ctl_pkg::SLP_GATED; // [RQ17]
        end
      end
      clk_ctl_pkg::SLP_GATED: begin
        if (!i_sleep_req) begin
          next_state = clk_ctl_pkg::SLP_IDLE;
        end
      end
    endcase
    if (o_chip_reset) begin
      next_state = clk_ctl_pkg::SLP_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state   <= clk_ctl_pkg::SLP_IDLE;
      pre     <= 4'h0;
      dly_cnt <= 24'h0;
    end else begin
      state   <= next_state;
      pre     <= next_pre;
      dly_cnt <= next_dly_cnt;
    end
  end

  // Acknowledge is low in the delay phase and once gated; held high while waiting
  assign o_suspend_ack_n = !(state == clk_ctl_pkg::SLP_ACK || state == clk_ctl_pkg::SLP_GATED); // [RQ7]

  // Kill mask overrides everything; PM gating applies only once gated
  assign o_clk_run = ~kill & ~((state == clk_ctl_pkg::SLP_GATED) ? {1'b0, i_pm_clk_disable}
                                                                  : 47'h0); // [RQ1]

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_kill_stops_clock: assert property (!(|(kill & o_clk_run))) // [RQ1]
    else $error("killed clock still running");
  a_status_pll_read: assert property (rd && i_msr.addr == clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS
    && !o_chip_reset |=> o_msr_rsp && o_msr_rdata[46] == !$past(kill[46])) // [RQ3]
    else $error("status PLL bit not inverse of kill bit");
  a_status_req_read: assert property (rd && i_msr.addr == clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS
    && !o_chip_reset |=> o_msr_rdata[45:0] == $past(i_clk_req)
    && o_msr_rdata[63:47] == 17'h0) // [RQ4] [RQ6]
    else $error("status request bits wrong");
  a_ack_held_high: assert property (state == clk_ctl_pkg::SLP_WAIT && i_sleep_req // [RQ7]
    && monitored_busy && !(i_gating_delay != 24'h0 && dly_cnt == 24'h0) && !o_chip_reset
    |=> o_suspend_ack_n)
    else $error("acknowledge given with monitored clock busy");
  a_ack_on_idle: assert property (state == clk_ctl_pkg::SLP_WAIT && i_sleep_req && !monitored_busy
    && !o_chip_reset |=> !o_suspend_ack_n) // [RQ8]
    else $error("acknowledge not given after clocks idle");
  a_delay_ignores_mask: assert property (state == clk_ctl_pkg::SLP_IDLE && i_sleep_req
    && i_delay_gating_select && !o_chip_reset |=> !o_suspend_ack_n ##0 state != clk_ctl_pkg::SLP_WAIT) // [RQ17]
    else $error("delay gating waited on monitor mask");
  a_chip_reset_clears: assert property (o_chip_reset |=> kill == 47'h0 && rst_spare == 23'h0
    && sleep_monitor_bits == 46'h0 && !o_chip_reset) // [RQ10]
    else $error("chip reset did not clear registers");
  a_no_reset_response: assert property (chip_rst_wr && !o_chip_reset |=> !o_msr_rsp && o_chip_reset) // [RQ12]
    else $error("chip reset write got a response");
  a_spare_storage: assert property (wr && i_msr.addr == clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL
    && !i_msr.wdata[0] && !o_chip_reset |=> rst_spare == $past(i_msr.wdata[23:1])) // [RQ13]
    else $error("reset register spare bits not stored");
  a_revision_read: assert property (rd && i_msr.addr == clk_ctl_pkg::ADDR_SILICON_REVISION_ID
    && !o_chip_reset |=> o_msr_rdata == {56'h0, REVISION}) // [RQ15]
    else $error("revision read wrong");
  a_timeout_unit: assert property (state == clk_ctl_pkg::SLP_WAIT && i_pci_tick && !unit_tick
    && !o_chip_reset |=> dly_cnt == $past(dly_cnt)) // [RQ19]
    else $error("delay counted faster than sixteen PCI cycles");

  // Register port and sleep sequencing detail
  a_no_stray_rsp: assert property (!i_msr.valid || chip_rst_wr || o_chip_reset // [RQ12]
    |=> !o_msr_rsp)
    else $error("response without an accepted request");
  a_kill_write: assert property (wr && !o_chip_reset // [RQ1]
    && i_msr.addr == clk_ctl_pkg::ADDR_CLOCK_KILL_MASK
    |=> kill == $past(i_msr.wdata[46:0]))
    else $error("kill mask write not stored");
  a_monitor_write: assert property (wr && !o_chip_reset // [RQ8]
    && i_msr.addr == clk_ctl_pkg::ADDR_SLEEP_MONITOR_MASK
    |=> sleep_monitor_bits == $past(i_msr.wdata[45:0]))
    else $error("sleep monitor mask write not stored");
  a_status_kill_req: assert property (rd && !o_chip_reset // [RQ5]
    && i_msr.addr == clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS && |(kill[45:0] & i_clk_req)
    |=> (o_msr_rdata[45:0] & $past(kill[45:0])) == ($past(i_clk_req) & $past(kill[45:0])))
    else $error("killed clock hides its request");
  a_reset_upper_zero: assert property (rd && !o_chip_reset // [RQ14]
    && i_msr.addr == clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL
    |=> o_msr_rdata[63:24] == 40'h0 && !o_msr_rdata[clk_ctl_pkg::CHIP_RESET_BIT])
    else $error("reset register reserved bits not zero");
  a_spare_readback: assert property (rd && !o_chip_reset // [RQ13]
    && i_msr.addr == clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL
    |=> o_msr_rdata[23:1] == $past(rst_spare))
    else $error("reset register spare bits not read back");
  a_chip_reset_idle: assert property (o_chip_reset // [RQ10]
    |=> state == clk_ctl_pkg::SLP_IDLE && o_suspend_ack_n)
    else $error("chip reset left sleep sequencing active");
  a_pll_kill_only: assert property (o_clk_run[clk_ctl_pkg::PLL_BIT] // [RQ1] [RQ3]
    == !kill[clk_ctl_pkg::PLL_BIT])
    else $error("PLL clock gated by other than its kill bit");
  a_delay_holds: assert property (state == clk_ctl_pkg::SLP_ACK && i_sleep_req // [RQ17]
    && dly_cnt != 24'h0 && !o_chip_reset |=> state == clk_ctl_pkg::SLP_ACK)
    else $error("delay gating ended early");
  a_delay_gates: assert property (state == clk_ctl_pkg::SLP_ACK && i_sleep_req // [RQ17]
    && dly_cnt == 24'h0 && !o_chip_reset |=> state == clk_ctl_pkg::SLP_GATED)
    else $error("delay gating did not gate");
  a_timeout_gates: assert property (state == clk_ctl_pkg::SLP_WAIT && i_sleep_req // [RQ18]
    && i_gating_delay != 24'h0 && dly_cnt == 24'h0 && !o_chip_reset |=> !o_suspend_ack_n)
    else $error("wait for idle clocks did not time out");
  a_unit_step: assert property (state != clk_ctl_pkg::SLP_IDLE && unit_tick // [RQ19]
    && dly_cnt != 24'h0 && !o_chip_reset |=> dly_cnt == $past(dly_cnt) - 24'h1)
    else $error("delay did not step once per sixteen PCI cycles");
  a_sleep_exit: assert property (state != clk_ctl_pkg::SLP_IDLE && !i_sleep_req // [RQ7]
    |=> o_suspend_ack_n)
    else $error("acknowledge held after sleep request dropped");

  c_chip_reset: cover property (chip_rst_wr);
  c_gated_by_idle: cover property (state == clk_ctl_pkg::SLP_WAIT ##1 state == clk_ctl_pkg::SLP_GATED);
  c_timeout: cover property (state == clk_ctl_pkg::SLP_WAIT && monitored_busy
    ##1 state == clk_ctl_pkg::SLP_GATED);
  c_delay_path: cover property (state == clk_ctl_pkg::SLP_ACK ##1 state == clk_ctl_pkg::SLP_GATED);
  c_killed_request: cover property (rd && i_msr.addr == clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS
    && |(kill[45:0] & i_clk_req));

endmodule

/* dv/pm_blocks_model.sv */
// Model of the clocked blocks that raise clock requests, and of the PCI tick.
// Assumes one core clock; the bench sets which requests the blocks want.
module pm_blocks_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [45:0] i_want,
  input  wire logic        i_slow,
  output logic      [45:0] o_clk_req,
  output logic             o_pci_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lag;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_req  <= '0;
      o_pci_tick <= 1'h0;
      lag        <= 2'h0;
    end else begin
      o_pci_tick <= ~o_pci_tick;
      // Slow blocks take three extra cycles to change their requests
      lag <= (i_want != o_clk_req && i_slow) ? lag + 2'h1 : 2'h0;
      if (!i_slow || lag == 2'h3) o_clk_req <= i_want;
    end
  end
endmodule

/* dv/clock_gate_and_chip_reset_ctl_test.sv */
// Self-checking bench for the clock gating and chip reset control block.
// Assumes each accepted register request is answered one cycle later.
module clock_gate_and_chip_reset_ctl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'h5a;  // Arbitrary value
  localparam logic [31:0] regs [7] = '{clk_ctl_pkg::ADDR_CLOCK_KILL_MASK,
    clk_ctl_pkg::ADDR_DEBUG_CLOCK_STOP_MASK, clk_ctl_pkg::ADDR_SLEEP_MONITOR_MASK,
    clk_ctl_pkg::ADDR_SYSTEM_RESET_CONTROL, clk_ctl_pkg::ADDR_DEBUG_CLOCK_CONTROL,
    clk_ctl_pkg::ADDR_SILICON_REVISION_ID, 32'h5170_0015};
  localparam logic [63:0] rstv [7] = '{64'h0, 64'h0, 64'h0, 64'h0,
    clk_ctl_pkg::RST_DEBUG_CLOCK_CONTROL, {56'h0, REV}, 64'h0};
  logic                  i_core_clk = 1'h0;
  logic                  i_rst = 1'h1;
  logic                  i_sleep_req = 1'h0;
  logic                  slow = 1'h0;
  logic                  i_delay_gating_select = 1'h0;
  clk_ctl_pkg::msr_req_t i_msr = '0;
  logic [45:0]           want = '0;
  logic [45:0]           i_pm_clk_disable = '0;
  logic [23:0]           i_gating_delay = 24'h0;
  logic [45:0]           i_clk_req;
  logic                  i_pci_tick, o_msr_rsp, o_suspend_ack_n, o_chip_reset;
  logic [63:0]           o_msr_rdata, kill, w;
  logic [46:0]           o_clk_run;
  logic [64:0]           q[$], e;
  int                    n_errors = 0, checks_done = 0;

  always #20 i_core_clk = ~i_core_clk;

  clock_gate_and_chip_reset_ctl #(.REVISION(REV)) i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_msr(i_msr), .o_msr_rsp(o_msr_rsp),
    .o_msr_rdata(o_msr_rdata), .i_clk_req(i_clk_req), .i_pm_clk_disable(i_pm_clk_disable),
    .i_delay_gating_select(i_delay_gating_select), .i_gating_delay(i_gating_delay),
    .i_pci_tick(i_pci_tick), .i_sleep_req(i_sleep_req), .o_suspend_ack_n(o_suspend_ack_n),
    .o_clk_run(o_clk_run), .o_chip_reset(o_chip_reset));
  pm_blocks_model i_blocks (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_want(want),
    .i_slow(slow), .o_clk_req(i_clk_req), .o_pci_tick(i_pci_tick));

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Requests stay valid back to back until cyc lowers valid
  task automatic req(logic w_en, logic [31:0] a, logic [63:0] d, logic [63:0] exp);
    i_msr = '{1'h1, w_en, a, d};
    if (!(w_en && a == regs[3] && d[0])) q.push_back({!w_en, exp});
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic cyc(int n);
    i_msr.valid = 1'h0;
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(negedge i_core_clk) begin
    if (!i_rst && o_msr_rsp === 1'h1) begin
      if (q.size() == 0) chk("unexpected response", 64'h0, 64'h1);
      else begin
        e = q.pop_front();
        if (e[64]) chk("read data", e[63:0], o_msr_rdata);
      end
    end
  end

  initial begin
    #200000;
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    complete_run();
  end

  initial begin
    void'($urandom(17));
    repeat (6) @(posedge i_core_clk);
    #1;
    i_rst = 1'h0;
    // Test-only registers are read here but never written
    foreach (regs[i]) req(1'h0, regs[i], 64'h0, rstv[i]);
    kill = {$urandom, $urandom};
    want = 46'({$urandom, $urandom});
    i_pm_clk_disable = 46'({$urandom, $urandom});
    w = {$urandom, $urandom};
    w[0] = 1'h0;
    // Kill mask is written in this debug scenario, cleared after it, and set again before the chip reset
    req(1'h1, regs[0], kill, 64'h0);
    req(1'h1, clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS, '1, 64'h0);
    req(1'h1, regs[5], '1, 64'h0);
    req(1'h1, regs[3], w, 64'h0);
    req(1'h0, regs[0], 64'h0, {17'h0, kill[46:0]});
    req(1'h0, regs[3], 64'h0, {40'h0, w[23:1], 1'h0});
    req(1'h0, regs[5], 64'h0, {56'h0, REV});
    cyc(3);
    chk("clock run", {17'h0, ~kill[46:0]}, {17'h0, o_clk_run});
    req(1'h0, clk_ctl_pkg::ADDR_CLOCK_REQUEST_STATUS, 64'h0,
        {17'h0, ~kill[46], want});
    req(1'h1, regs[0], 64'h0, 64'h0);
    req(1'h1, regs[2], 64'h20, 64'h0);
    want[5] = 1'h1;
    slow = 1'h1;
    cyc(4);
    i_sleep_req = 1'h1;
    cyc(6);
    chk("ack held", 64'h1, {63'h0, o_suspend_ack_n});
    want[5] = 1'h0;
    for (int i = 0; i < 12 && o_suspend_ack_n !== 1'h0; i++) cyc(1);
    chk("ack given", 64'h0, {63'h0, o_suspend_ack_n});
    chk("gated run", {17'h0, 1'h1, ~i_pm_clk_disable}, {17'h0, o_clk_run});
    i_sleep_req = 1'h0;
    cyc(2);
    chk("ack released", 64'h1, {63'h0, o_suspend_ack_n});
    chk("run restored", {17'h0, {47{1'h1}}}, {17'h0, o_clk_run});
    want[5] = 1'h1;
    i_delay_gating_select = 1'h1;
    i_gating_delay = 24'h1;
    cyc(4);
    i_sleep_req = 1'h1;
    cyc(2);
    chk("delay ack", 64'h0, {63'h0, o_suspend_ack_n});
    cyc(18);
    chk("delay early", {17'h0, {47{1'h1}}}, {17'h0, o_clk_run});
    cyc(20);
    chk("delay gated", {17'h0, 1'h1, ~i_pm_clk_disable}, {17'h0, o_clk_run});
    i_sleep_req = 1'h0;
    i_delay_gating_select = 1'h0;
    cyc(2);
    // Monitored clock stays busy, so only the nonzero delay ends the wait
    i_sleep_req = 1'h1;
    cyc(20);
    chk("timeout early", 64'h1, {63'h0, o_suspend_ack_n});
    cyc(20);
    chk("timeout ack", 64'h0, {63'h0, o_suspend_ack_n});
    chk("timeout gated", {17'h0, 1'h1, ~i_pm_clk_disable}, {17'h0, o_clk_run});
    i_sleep_req = 1'h0;
    cyc(2);
    req(1'h1, regs[0], 64'h7, 64'h0);
    req(1'h1, regs[3], 64'h1, 64'h0);
    for (int i = 0; i < 4 && o_chip_reset !== 1'h1; i++) cyc(1);
    chk("chip reset", 64'h1, {63'h0, o_chip_reset});
    chk("run before reset", {17'h0, ~47'h7}, {17'h0, o_clk_run});
    cyc(2);
    chk("run after reset", {17'h0, {47{1'h1}}}, {17'h0, o_clk_run});
    foreach (regs[i]) req(1'h0, regs[i], 64'h0, rstv[i]);
    cyc(3);
    chk("queue drained", 64'h0, 64'(q.size()));
    complete_run();
  end
endmodule
